// [src/psbi_pkg.sv]
// Shared constants, types and carriers of the pipelined burst memory interface.
package psbi_pkg;
	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 20;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int DATA_W = LANES * LANE_W;
	localparam int WORDS = 2 ** ADDR_W;
	localparam int CNT_W = 2;
	localparam int HI_W = ADDR_W - CNT_W;
	localparam int FIFO_DEPTH = 4;

	// ----------------------------------------------------------------
	// Field values
	// ----------------------------------------------------------------
	localparam logic [LANES-1:0] LANE_ALL = 4'hF;
	localparam logic [LANES-1:0] LANE_NONE = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;
	localparam logic [CNT_W-1:0] CNT_STEP = 2'h1;
	localparam logic [DATA_W-1:0] DATA_ZERO = 36'h0;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 20'h0;

	// ----------------------------------------------------------------
	// Interface state
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_ACTIVE = 3'h2,
		ST_SLEEP = 3'h4
	} psbi_state_t;

	// One posted write on its way into the array.
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [LANES-1:0] mask;
	} psbi_wr_req_t;

	localparam int WR_REQ_W = $bits(psbi_wr_req_t);
endpackage

// [src/psbi_sram.sv]
// Pipelined double-cycle-deselect burst memory interface with its array and write FIFO.
// Notes on behaviour
// - Strobe low, all selects active, write qualifiers high starts a single read.
// - An access start captures the address into address register and burst counter.
// - Read data leaves the output register after the next edge when drive enable low.
// - Emerging from deselect, outputs stay high impedance during the first access cycle.
// - After a registered deselect, outputs keep driving one more cycle, then release.
// - Processor strobe access always starts as read; write inputs and advance ignored.
// - Processor strobe write completes on the second edge using global or byte write.
// - Controller strobe write with chip selected completes in one cycle, advance ignored.
// - Global write low writes all four lanes regardless of byte enables.
// - Byte write enable low writes only lanes whose select is low.
// - Global write high with byte enable high or no lane selected is a read.
// - Outputs forced to high impedance whenever a write cycle is detected.
// - Drive enable is unclocked, masked during writes, enables outputs only while low.
// - Two-bit wraparound burst counter loaded from the lowest address bits, reads and writes.
// - Advance low with both strobes high steps the counter to the next burst address.
// - Order strap high gives interleaved order, start XOR count.
// - Order strap low gives linear order, start plus count modulo four.
// - Strobes inactive and advance low continue the burst; chip selects ignored.
// - Strobes inactive and advance high suspend the burst at the current address.
// - Controller strobe with select one high, or bad selects two or three, deselect.
// - Sleep request enters low-power sleep, outputs off, contents kept, two cycles each way.
// - Both strobes low with select one low recognise only the processor strobe.
// - Select two active high, selects one and three active low, sampled at address load.

// ------------------------------------------------------------------------
// Write FIFO
// ------------------------------------------------------------------------
module psbi_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Fill side
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [W-1:0] i_data,
	// Drain side
	output logic o_valid,
	input wire logic i_ready,
	output logic [W-1:0] o_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
	localparam logic [AW:0] EMPTY = '0;

	logic [W-1:0] buf_q [0:DEPTH-1];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	assign o_ready = cnt_q != FULL;
	assign o_valid = cnt_q != EMPTY;
	assign o_data = buf_q[rp_q];
	assign push = i_valid && o_ready;
	assign pop = o_valid && i_ready;

	always_ff @(posedge i_clk) begin
		if (push) begin
			buf_q[wp_q] <= i_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			if (push) begin
				wp_q <= wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= rp_q + 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_q <= '0;
		end else if (push && !pop) begin
			cnt_q <= cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule

// ------------------------------------------------------------------------
// Memory interface top
// ------------------------------------------------------------------------
module psbi_sram
	import psbi_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Address and burst control
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic i_processor_addr_strobe_n,
	input wire logic i_controller_addr_strobe_n,
	input wire logic i_burst_advance_n,
	input wire logic i_chip_sel1_n,
	input wire logic i_chip_sel2,
	input wire logic i_chip_sel3_n,
	// Write qualifiers
	input wire logic i_global_write_n,
	input wire logic i_byte_write_enable_n,
	input wire logic [LANES-1:0] i_byte_lane_select_n,
	// Asynchronous controls and strap
	input wire logic i_output_drive_n,
	input wire logic i_sleep_request,
	input wire logic i_burst_order,
	// Data bus, data and parity_lines per lane
	input wire logic [DATA_W-1:0] i_dq,
	output logic [DATA_W-1:0] o_dq,
	output logic o_dq_oe_n,
	// Status
	output logic o_sleep
);
	// --------------------------------------------------------------------
	// Declarations
	// --------------------------------------------------------------------
	logic [DATA_W-1:0] mem_q [0:WORDS-1];
	psbi_state_t st_q;
	logic [HI_W-1:0] hi_q;
	logic [CNT_W-1:0] lo_q;
	logic [CNT_W-1:0] cnt_q;
	logic [ADDR_W-1:0] rd_addr_q;
	logic rd_pend_q;
	logic drive_q;
	logic [DATA_W-1:0] dout_q;
	logic zz_s1_q;
	logic zz_s2_q;
	logic mode_s1_q;
	logic mode_s2_q;
	logic sleep_q;
	logic sel_ok;
	logic [LANES-1:0] wr_mask;
	logic go;
	logic is_wr;
	logic use_ext;
	logic burst_advance_n;
	logic desel;
	logic [CNT_W-1:0] cnt_d;
	logic [ADDR_W-1:0] acc_addr;
	psbi_wr_req_t wr_req;
	psbi_wr_req_t wr_head;
	logic fifo_ready;
	logic fifo_valid;
	logic [WR_REQ_W-1:0] fifo_out;

	// Burst address of step cnt from start: interleaved XOR or linear sum.
	function automatic logic [CNT_W-1:0] burst_lo(
		input logic [CNT_W-1:0] start,
		input logic [CNT_W-1:0] cnt,
		input logic interleaved
	);
		burst_lo = interleaved ? (start ^ cnt) : (start + cnt);
	endfunction

	// --------------------------------------------------------------------
	// Asynchronous pins
	// --------------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			zz_s1_q <= 1'b0;
			zz_s2_q <= 1'b0;
			mode_s1_q <= 1'b1;
			mode_s2_q <= 1'b1;
		end else begin
			zz_s1_q <= i_sleep_request;
			zz_s2_q <= zz_s1_q;
			mode_s1_q <= i_burst_order;
			mode_s2_q <= mode_s1_q;
		end
	end

	// --------------------------------------------------------------------
	// Cycle decode
	// --------------------------------------------------------------------
	assign sel_ok = !i_chip_sel1_n && i_chip_sel2 && !i_chip_sel3_n;

	always_comb begin
		// Global write overrides the byte enables.
		if (!i_global_write_n) begin
			wr_mask = LANE_ALL;
		end else if (!i_byte_write_enable_n) begin
			wr_mask = ~i_byte_lane_select_n;
		end else begin
			wr_mask = LANE_NONE;
		end
	end

	always_comb begin
		go = 1'b0;
		is_wr = 1'b0;
		use_ext = 1'b0;
		burst_advance_n = 1'b0;
		desel = 1'b0;
		if (st_q == ST_SLEEP) begin
			go = 1'b0;
		end else if (!i_processor_addr_strobe_n && !i_chip_sel1_n) begin
			// Controller strobe is not looked at here, and this cycle never writes.
			go = sel_ok;
			use_ext = sel_ok;
			desel = !sel_ok;
		end else if (!i_controller_addr_strobe_n) begin
			go = sel_ok;
			use_ext = sel_ok;
			is_wr = sel_ok && (wr_mask != LANE_NONE);
			desel = !sel_ok;
		end else if (st_q == ST_ACTIVE) begin
			// Burst continue or suspend; the chip selects are not sampled.
			go = 1'b1;
			burst_advance_n = !i_burst_advance_n;
			is_wr = wr_mask != LANE_NONE;
		end
	end

	assign cnt_d = use_ext ? CNT_ZERO : (burst_advance_n ? cnt_q + CNT_STEP : cnt_q);
	assign acc_addr = use_ext ? i_addr : {hi_q, burst_lo(lo_q, cnt_d, mode_s2_q)};

	// --------------------------------------------------------------------
	// Interface state and address register
	// --------------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_q <= ST_IDLE;
		end else begin
			unique case (st_q)
				ST_IDLE, ST_ACTIVE: begin
					if (zz_s2_q) begin
						st_q <= ST_SLEEP;
					end else if (use_ext) begin
						st_q <= ST_ACTIVE;
					end else if (desel) begin
						st_q <= ST_IDLE;
					end
				end
				ST_SLEEP: begin
					if (!zz_s2_q) begin
						st_q <= ST_IDLE;
					end
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			hi_q <= '0;
			lo_q <= CNT_ZERO;
			cnt_q <= CNT_ZERO;
		end else if (go) begin
			if (use_ext) begin
				hi_q <= i_addr[ADDR_W-1:CNT_W];
				lo_q <= i_addr[CNT_W-1:0];
			end
			cnt_q <= cnt_d;
		end
	end

	// --------------------------------------------------------------------
	// Write path: posted through the FIFO, drained while awake
	// --------------------------------------------------------------------
	// A write that meets a full FIFO is dropped; this never happens, since writes are
	// accepted only while awake, when one entry drains each cycle, so at most one is held.
	assign wr_req = '{addr: acc_addr, data: i_dq, mask: wr_mask};
	assign wr_head = psbi_wr_req_t'(fifo_out);

	psbi_fifo #(
		.W(WR_REQ_W),
		.DEPTH(FIFO_DEPTH)
	) u_wr_fifo (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_valid(go && is_wr),
		.o_ready(fifo_ready),
		.i_data(WR_REQ_W'(wr_req)),
		.o_valid(fifo_valid),
		.i_ready(st_q != ST_SLEEP),
		.o_data(fifo_out)
	);

	// Lanes not selected keep their contents.
	always_ff @(posedge i_clk) begin
		if (fifo_valid && st_q != ST_SLEEP) begin
			for (int l = 0; l < LANES; l++) begin
				if (wr_head.mask[l]) begin
					mem_q[wr_head.addr][l*LANE_W +: LANE_W] <= wr_head.data[l*LANE_W +: LANE_W];
				end
			end
		end
	end

	// --------------------------------------------------------------------
	// Read pipeline and output drive
	// --------------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rd_pend_q <= 1'b0;
			rd_addr_q <= ADDR_ZERO;
		end else begin
			rd_pend_q <= go && !is_wr;
			if (go && !is_wr) begin
				rd_addr_q <= acc_addr;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			dout_q <= DATA_ZERO;
		end else if (rd_pend_q) begin
			dout_q <= mem_q[rd_addr_q];
		end
	end

	// Drive follows the read one edge late, which gives the first-cycle
	// high impedance and the extra deselect cycle for free.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			drive_q <= 1'b0;
		end else begin
			drive_q <= rd_pend_q && !(go && is_wr) && st_q != ST_SLEEP;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sleep_q <= 1'b0;
		end else begin
			sleep_q <= st_q == ST_SLEEP;
		end
	end

	assign o_dq = dout_q;
	// Drive enable must stay unclocked, so this one output passes a gate.
	assign o_dq_oe_n = !drive_q || i_output_drive_n;
	assign o_sleep = sleep_q;

	// --------------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------------
	chk_read_drives: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(go && !is_wr) ##1 (!(go && is_wr) && st_q != ST_SLEEP) |=> drive_q)
		else $error("read did not drive the bus");
	chk_first_hiz: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(!rd_pend_q && go && !is_wr) |=> !drive_q)
		else $error("bus driven in first cycle after deselect");
	chk_dcd_release: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(desel && rd_pend_q && !zz_s2_q) |=> drive_q ##1 !drive_q)
		else $error("deselect release not one cycle late");
	chk_write_hiz: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(go && is_wr) |=> !drive_q && o_dq_oe_n)
		else $error("bus driven during write");
	chk_proc_read: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(st_q != ST_SLEEP && !i_processor_addr_strobe_n && sel_ok) |=> rd_pend_q && cnt_q == CNT_ZERO)
		else $error("processor strobe did not start a read");
	chk_load_addr: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(go && use_ext) |=> lo_q == $past(i_addr[CNT_W-1:0]) && st_q != ST_IDLE)
		else $error("start address not captured");
	chk_burst_step: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(go && !use_ext && burst_advance_n) |=> cnt_q == CNT_W'($past(cnt_q) + CNT_STEP))
		else $error("burst counter did not step");
	chk_suspend_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(go && !use_ext && !burst_advance_n) |=> $stable(cnt_q))
		else $error("burst counter moved during suspend");
	chk_sleep_entry: assert property (@(posedge i_clk) disable iff (!i_rstn)
		$rose(zz_s2_q) |=> st_q == ST_SLEEP ##1 (o_sleep && !drive_q))
		else $error("sleep not entered in time");
	chk_gw_all: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(go && is_wr && !i_global_write_n) |-> wr_req.mask == LANE_ALL)
		else $error("global write missed a lane");

	cov_read: cover property (@(posedge i_clk) disable iff (!i_rstn)
		(go && use_ext && !is_wr) ##2 drive_q);
	cov_ctrl_write: cover property (@(posedge i_clk) disable iff (!i_rstn)
		go && use_ext && is_wr);
	cov_burst4: cover property (@(posedge i_clk) disable iff (!i_rstn)
		(go && use_ext) ##1 (go && burst_advance_n)[*3]);
	cov_sleep: cover property (@(posedge i_clk) disable iff (!i_rstn)
		(st_q == ST_SLEEP) ##1 (st_q == ST_IDLE));
endmodule

// [verif/psbi_bus_master.sv]
// Processor-side bus master model that drives the burst memory interface.
module psbi_bus_master
	import psbi_pkg::*;
(
	// Clock and returned data
	input wire logic i_clk,
	input wire logic [DATA_W-1:0] i_q,
	input wire logic i_q_oe_n,
	// Bus towards the memory
	output logic [ADDR_W-1:0] o_addr,
	output logic o_ps_n,
	output logic o_cs_n,
	output logic o_adv_n,
	output logic o_sel1_n,
	output logic o_gw_n,
	output logic o_bwe_n,
	output logic [LANES-1:0] o_lane_n,
	output logic o_drive_n,
	output logic o_sleep_req,
	output logic [DATA_W-1:0] o_d
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Cycle driver
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] q_seen;
	logic oe_seen;

	initial begin
		{o_ps_n, o_cs_n, o_adv_n, o_sel1_n, o_gw_n, o_bwe_n} = 6'h3F;
		o_addr = ADDR_ZERO;
		o_lane_n = LANE_ALL;
		o_drive_n = 1'b1;
		o_sleep_req = 1'b0;
		o_d = DATA_ZERO;
	end

	// Samples the bus first, then presents one cycle for the next rising edge.
	task automatic cyc(input logic [5:0] c, input logic [LANES-1:0] ln,
		input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		logic wr;
		@(negedge i_clk);
		q_seen = i_q;
		oe_seen = i_q_oe_n;
		wr = c[5] & (!c[1] | (!c[0] & (ln != LANE_ALL)));
		if (wr) begin
			o_drive_n = 1'b1;
			#1;
		end else begin
			o_drive_n = 1'b0;
		end
		{o_ps_n, o_cs_n, o_adv_n, o_sel1_n, o_gw_n, o_bwe_n} = c;
		o_lane_n = ln;
		o_addr = a;
		// A released bus keeps changing so stale data cannot pass for a read.
		o_d = wr ? d : ~o_d;
	endtask

	// ----------------------------------------------------------------
	// Sleep handshake
	// ----------------------------------------------------------------
	// The deselect is registered first; the strobes then stay idle through sleep.
	task automatic sleep_on();
		cyc(6'h2F, LANE_ALL, ADDR_ZERO, DATA_ZERO);
		cyc(6'h3F, LANE_ALL, ADDR_ZERO, DATA_ZERO);
		o_sleep_req = 1'b1;
	endtask

	task automatic sleep_off();
		@(negedge i_clk);
		o_sleep_req = 1'b0;
		repeat (2) cyc(6'h3F, LANE_ALL, ADDR_ZERO, DATA_ZERO);
	endtask
endmodule

// [verif/tb_psbi_sram.sv]
// Self-checking bench of the pipelined burst memory interface.
module tb_psbi_sram
	import psbi_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Cycle codes: proc, ctrl, advance, select one, global, byte enable
	// ----------------------------------------------------------------
	localparam logic [5:0] RD_P = 6'h1B;
	localparam logic [5:0] CONT = 6'h33;
	localparam logic [5:0] DESEL = 6'h2F;
	localparam logic [5:0] CWR = 6'h29;
	localparam logic [5:0] CBW = 6'h2A;
	localparam logic [5:0] SUSW = 6'h39;
	localparam logic [5:0] BOTH = 6'h09;
	localparam logic [ADDR_W-1:0] BASE = 20'h01230;
	localparam logic [ADDR_W-1:0] A1 = 20'h0ABCD;
	localparam logic [ADDR_W-1:0] A2 = 20'hFFFFE;

	logic clk, rstn, strap, ps_n, cs_n, adv_n, sel1_n, gw_n, bwe_n, drive_n, sleep_req;
	logic dq_oe_n, sleep;
	logic sel2, sel3_n;
	logic [ADDR_W-1:0] addr;
	logic [LANES-1:0] lane_n;
	logic [DATA_W-1:0] d, q;
	logic [DATA_W-1:0] exp_mem [int];
	int n_mismatch = 0;
	int tests_run = 0;
	int cycles = 0;

	psbi_sram uut (.i_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_processor_addr_strobe_n(ps_n),
		.i_controller_addr_strobe_n(cs_n), .i_burst_advance_n(adv_n), .i_chip_sel1_n(sel1_n),
		.i_chip_sel2(sel2), .i_chip_sel3_n(sel3_n), .i_global_write_n(gw_n),
		.i_byte_write_enable_n(bwe_n), .i_byte_lane_select_n(lane_n), .i_output_drive_n(drive_n),
		.i_sleep_request(sleep_req), .i_burst_order(strap), .i_dq(d), .o_dq(q),
		.o_dq_oe_n(dq_oe_n), .o_sleep(sleep));

	psbi_bus_master m (.i_clk(clk), .i_q(q), .i_q_oe_n(dq_oe_n), .o_addr(addr), .o_ps_n(ps_n),
		.o_cs_n(cs_n), .o_adv_n(adv_n), .o_sel1_n(sel1_n), .o_gw_n(gw_n), .o_bwe_n(bwe_n),
		.o_lane_n(lane_n), .o_drive_n(drive_n), .o_sleep_req(sleep_req), .o_d(d));

	// ----------------------------------------------------------------
	// Clock, timeout and reporting
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			n_mismatch++;
			$display("[FAIL] t=%0t run did not finish in time", $time);
			complete_run();
		end
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] want);
		tests_run++;
		if (got !== want) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got %h expected %h", $time, got, want);
		end
	endtask

	// Read data of a single access shows two edges after it is started.
	task automatic read_one(input logic [ADDR_W-1:0] a);
		m.cyc(DESEL, LANE_ALL, a, DATA_ZERO);
		m.cyc(RD_P, LANE_ALL, a, DATA_ZERO);
		repeat (2) m.cyc(DESEL, LANE_ALL, a, DATA_ZERO);
		check(m.q_seen, exp_mem[a]);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_burst(input logic mode, input logic [1:0] s);
		logic [1:0] lo;
		logic [5:0] c;
		logic [ADDR_W-1:0] a;
		strap = mode;
		for (int i = 0; i < 4; i++) begin
			a = {BASE[ADDR_W-1:CNT_W], 2'(i)};
			exp_mem[a] = {8'hC3, 7'h00, mode, a};
			m.cyc(CWR, LANE_ALL, a, exp_mem[a]);
		end
		repeat (3) m.cyc(DESEL, LANE_ALL, BASE, DATA_ZERO);
		for (int j = 0; j < 7; j++) begin
			c = (j == 0) ? RD_P : (j < 4) ? CONT : DESEL;
			m.cyc(c, LANE_ALL, {BASE[ADDR_W-1:CNT_W], s}, DATA_ZERO);
			lo = mode ? (s ^ 2'(j - 2)) : (s + 2'(j - 2));
			if (j == 1 || j == 6) begin
				check(DATA_W'(m.oe_seen), 36'h1);
			end
			if (j >= 2 && j < 6) begin
				check(m.q_seen, exp_mem[{BASE[ADDR_W-1:CNT_W], lo}]);
				check(DATA_W'(m.oe_seen), 36'h0);
			end
			if (j == 2) begin
				m.o_drive_n = 1'b1;
				#1 check(DATA_W'(dq_oe_n), 36'h1);
				m.o_drive_n = 1'b0;
			end
		end
	endtask

	task automatic t_bytes();
		logic [DATA_W-1:0] v, e;
		v = 36'hF0F0F0F0F;
		exp_mem[A1] = 36'h123456789;
		m.cyc(CWR, LANE_NONE, A1, exp_mem[A1]);
		m.cyc(CBW, 4'hA, A1, v);
		e = exp_mem[A1];
		for (int l = 0; l < LANES; l += 2) begin
			e[l*LANE_W +: LANE_W] = v[l*LANE_W +: LANE_W];
		end
		exp_mem[A1] = e;
		m.cyc(CBW, LANE_ALL, A1, ~v);
		read_one(A1);
		m.cyc(BOTH, LANE_NONE, A1, ~v);
		read_one(A1);
		exp_mem[A1] = 36'h0DEADBEE5;
		m.cyc(RD_P, LANE_ALL, A1, DATA_ZERO);
		m.cyc(SUSW, LANE_ALL, A1, exp_mem[A1]);
		read_one(A1);
	endtask

	// A strobe with select two low, then select three high, must not start a read.
	task automatic t_desel();
		for (int k = 0; k < 2; k++) begin
			m.cyc(DESEL, LANE_ALL, A1, DATA_ZERO);
			sel2 = k[0];
			sel3_n = k[0];
			m.cyc(RD_P, LANE_ALL, A1, DATA_ZERO);
			repeat (2) m.cyc(DESEL, LANE_ALL, A1, DATA_ZERO);
			check(DATA_W'(m.oe_seen), 36'h1);
		end
		sel2 = 1'b1;
		sel3_n = 1'b0;
	endtask

	task automatic t_sleep();
		exp_mem[A2] = 36'h0A5A5A5A5;
		m.cyc(CWR, LANE_ALL, A2, exp_mem[A2]);
		m.sleep_on();
		for (int i = 0; i < 16 && sleep !== 1'b1; i++) begin
			@(negedge clk);
		end
		check(DATA_W'(sleep), 36'h1);
		check(DATA_W'(dq_oe_n), 36'h1);
		m.sleep_off();
		for (int i = 0; i < 16 && sleep !== 1'b0; i++) begin
			@(negedge clk);
		end
		check(DATA_W'(sleep), 36'h0);
		read_one(A2);
	endtask

	initial begin
		rstn = 1'b0;
		strap = 1'b1;
		sel2 = 1'b1;
		sel3_n = 1'b0;
		repeat (16) @(posedge clk);
		check(DATA_W'(dq_oe_n), 36'h1);
		@(negedge clk);
		rstn = 1'b1;
		t_burst(1'b1, 2'h1);
		t_burst(1'b0, 2'h3);
		t_bytes();
		t_desel();
		t_sleep();
		complete_run();
	end
endmodule
